//--- hdl/swu_pkg.sv
package swu_pkg;

	// System clock rate and the slowest bit time the receiver must handle.
	localparam int CLK_HZ = 40_000_000;
	localparam int MIN_BAUD = 9000;
	localparam logic [15:0] RST_BIT_CYC = 16'(CLK_HZ / MIN_BAUD);

	// Pulse on an idle line shorter than this many clocks is a glitch.
	localparam logic [17:0] GLITCH_CYC = 18'h10;

	// Link timing in bit times; the reply delay minimum in units of eight bit times.
	localparam logic [5:0] TIMEOUT_BITS = 6'h3f;
	localparam logic [3:0] RECOVER_BITS = 4'hc;
	localparam logic [2:0] TAIL_BITS = 3'h4;
	localparam logic [3:0] DELAY_MIN_UNITS = 4'h1;

	// Datagram layout.
	localparam logic [7:0] SYNC_BYTE = 8'h05;
	localparam logic [7:0] REPLY_ADDR = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [2:0] WR_LAST_BYTE = 3'h7;
	localparam logic [2:0] RD_LAST_BYTE = 3'h3;
	localparam int WFLAG_BIT = 7;

	// Bit positions inside one framed character, and the falling-edge count that ends measurement.
	localparam logic [3:0] BIT_START = 4'h0;
	localparam logic [3:0] BIT_STOP = 4'h9;
	localparam logic [3:0] BIT_SYNC_RESUME = 4'h4;
	localparam logic [1:0] MEAS_LAST_EDGE = 2'h1;

	// Values after reset.
	localparam logic [7:0] WCNT_RST = 8'h00;
	localparam logic CHAIN_OUT_RST = 1'b1;

	// Decoded write datagram handed to the register bank.
	typedef struct packed {
		logic [6:0] reg_addr;
		logic [31:0] data;
	} swu_wr_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MEAS,
		ST_RXBIT,
		ST_GAP,
		ST_RECOVER,
		ST_DELAY,
		ST_TXBIT,
		ST_TAIL
	} swu_state_t;

	// One serial step of the CRC, bits taken in line order.
	function automatic logic [7:0] swu_crc_step(input logic [7:0] crc, input logic din);
		swu_crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? CRC_POLY : 8'h00);
	endfunction : swu_crc_step

endpackage : swu_pkg

//--- hdl/swu_port.sv
`timescale 1ns/10ps
// How it works
// - Datagrams open with sync nibble, then address.
// - Each byte has low start, high stop.
// - Bit time measured start edge to sync bit3.
// - Bits LSB first, payload high byte first.
// - Write datagram is eight bytes with CRC.
// - Read request is four bytes, no payload.
// - Own address is setting plus increment pin.
// - Gap over 63 bit times resets receiver.
// - Glitch or CRC error forces 12-bit idle.
// - Good addressed writes bump wrapping write counter.
// - Ignore datagrams with bad CRC or address.
// - Reply uses the request's measured baud rate.
// - Reply waits programmable multiple of eight bits.
// - Reply carries all-ones address, register, data, CRC.
// - Drivers released four bit times after reply.
// - All-ones node address reserved for replies.
// - CRC8 x^8+x^2+x+1, zero start, LSB first.
// - Lines stay inputs except while replying.
// - Inverted line carries complement of true line.
// - Chain: first node address 0, others 1.
// - Chain output resets high, software changes it.
// - Counter wraps, idle in four-wire mode.
// - Write flag is register byte MSB.
module swu_port
	import swu_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// True data line, split into its three parts.
	input wire logic line_true_i,
	output logic line_true_o,
	output logic line_true_oe_o,
	// Inverted data line, split into its three parts.
	input wire logic line_inverted_i,
	output logic line_inverted_o,
	output logic line_inverted_oe_o,
	// Mode select pins.
	input wire logic four_wire_select_i,
	input wire logic step_direction_select_i,
	// Chained addressing pins and settings, plus the reply delay setting.
	input wire logic chain_addr_in_i,
	output logic chain_addr_out_o,
	input wire logic chain_addr_out_we_i,
	input wire logic chain_addr_out_d_i,
	input wire logic [7:0] node_address_setting_i,
	input wire logic [3:0] reply_delay_setting_i,
	// Register bank side.
	output logic wr_valid_o,
	output swu_wr_t wr_o,
	output logic rd_req_o,
	output logic [6:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	output logic [7:0] write_counter_o
);

	// Pin synchronisers: the first stage feeds only the second.
	logic [1:0] rx_sync_ff;
	logic [1:0] fw_sync_ff;
	logic [1:0] sd_sync_ff;
	logic [1:0] nai_sync_ff;
	logic rx_prev_ff;

	always_ff @(posedge mclk_i) begin
		rx_sync_ff <= {rx_sync_ff[0], line_true_i};
		fw_sync_ff <= {fw_sync_ff[0], four_wire_select_i};
		sd_sync_ff <= {sd_sync_ff[0], step_direction_select_i};
		nai_sync_ff <= {nai_sync_ff[0], chain_addr_in_i};
		rx_prev_ff <= rx_sync_ff[1];
	end

	// Edge detection and mode decode on synchronised levels.
	wire rx = rx_sync_ff[1];
	wire rx_fall = rx_prev_ff & ~rx;
	wire rx_rise = ~rx_prev_ff & rx;
	wire uart_en = ~fw_sync_ff[1] & ~sd_sync_ff[1];
	wire [7:0] my_addr = node_address_setting_i + {7'h00, nai_sync_ff[1]};

	// State registers.
	swu_state_t state_ff, nxt_state;
	logic [17:0] cnt_ff, nxt_cnt;
	logic [1:0] edges_ff, nxt_edges;
	logic [15:0] bit_ff, nxt_bit;
	logic [15:0] bit_good_ff, nxt_bit_good;
	logic [15:0] tmr_ff, nxt_tmr;
	logic [3:0] bidx_ff, nxt_bidx;
	logic [2:0] byte_ff, nxt_byte;
	logic [7:0] sh_ff, nxt_sh;
	logic [55:0] frame_ff, nxt_frame;
	logic [7:0] crc_ff, nxt_crc;
	logic [21:0] gap_ff, nxt_gap;
	logic [23:0] wait_ff, nxt_wait;
	logic [7:0] wcnt_ff, nxt_wcnt;
	logic wr_valid_ff, nxt_wr_valid;
	swu_wr_t wr_ff, nxt_wr;
	logic rd_req_ff, nxt_rd_req;
	logic [6:0] rd_addr_ff, nxt_rd_addr;
	logic line_out_ff;
	logic line_oe_ff;
	logic chain_out_ff;

	// Limits derived from the measured bit times.
	wire [21:0] timeout_lim = {6'h00, bit_good_ff} * {16'h0000, TIMEOUT_BITS};
	wire [23:0] recover_lim = {8'h00, bit_good_ff} * {20'h00000, RECOVER_BITS};
	wire [23:0] tail_lim = {8'h00, bit_ff} * {21'h000000, TAIL_BITS};
	wire [3:0] dly_units = (reply_delay_setting_i == 4'h0) ? DELAY_MIN_UNITS :
		reply_delay_setting_i;
	wire [23:0] delay_lim = {8'h00, bit_ff} * {17'h00000, dly_units, 3'b000};
	wire timed_out = gap_ff > timeout_lim;
	wire tmr_done = tmr_ff == 16'h0000;
	wire [15:0] bit_reload = bit_ff - 16'h0001;

	// Receive-side decode of the datagram held so far.
	wire wflag = frame_ff[WFLAG_BIT];
	wire rx_last = (byte_ff == WR_LAST_BYTE) || ((byte_ff == RD_LAST_BYTE) && !wflag);
	wire rx_is_write = byte_ff == WR_LAST_BYTE;
	wire [7:0] rx_node = rx_is_write ? frame_ff[47:40] : frame_ff[15:8];
	wire [6:0] rx_reg = rx_is_write ? frame_ff[38:32] : frame_ff[6:0];
	wire crc_ok = sh_ff == crc_ff;
	wire addr_ok = rx_node == my_addr;

	// Sync bits 0..2 are assumed correct and folded into the CRC up front.
	wire [7:0] crc_sync = swu_crc_step(swu_crc_step(swu_crc_step(CRC_INIT, SYNC_BYTE[0]),
		SYNC_BYTE[1]), SYNC_BYTE[2]);

	// Transmit-side selection of the current bit.
	wire [7:0] tx_byte = (byte_ff == WR_LAST_BYTE) ? crc_ff : frame_ff[55:48];
	wire [2:0] tx_sel = 3'(bidx_ff - 4'h1);
	wire tx_bit = (bidx_ff == BIT_START) ? 1'b0 :
		(bidx_ff == BIT_STOP) ? 1'b1 : tx_byte[tx_sel];

	// Main sequencer: measure, receive, decode, wait, reply.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_edges = edges_ff;
		nxt_bit = bit_ff;
		nxt_bit_good = bit_good_ff;
		nxt_tmr = tmr_ff;
		nxt_bidx = bidx_ff;
		nxt_byte = byte_ff;
		nxt_sh = sh_ff;
		nxt_frame = frame_ff;
		nxt_crc = crc_ff;
		nxt_gap = gap_ff;
		nxt_wait = wait_ff;
		nxt_wcnt = wcnt_ff;
		nxt_wr_valid = 1'b0;
		nxt_wr = wr_ff;
		nxt_rd_req = 1'b0;
		nxt_rd_addr = rd_addr_ff;
		case (state_ff)
			ST_IDLE: begin
				if (rx_fall) begin
					nxt_state = ST_MEAS;
					nxt_cnt = 18'h00001; // The edge cycle counts, so four bits give 4B.
					nxt_edges = 2'h0;
					nxt_gap = 22'h000000;
				end
			end
			ST_MEAS: begin
				nxt_cnt = cnt_ff + 18'h00001;
				nxt_gap = gap_ff + 22'h000001;
				if (rx_rise && (edges_ff == 2'h0) && (cnt_ff < GLITCH_CYC)) begin
					nxt_state = ST_RECOVER;
					nxt_wait = 24'h000000;
				end else if (&cnt_ff) begin
					nxt_state = ST_RECOVER;
					nxt_wait = 24'h000000;
				end else if (rx_fall) begin
					if (edges_ff == MEAS_LAST_EDGE) begin
						// Four bit times have passed: start bit and sync bits 0..2.
						nxt_bit = cnt_ff[17:2];
						nxt_tmr = {1'b0, cnt_ff[17:3]};
						nxt_bidx = BIT_SYNC_RESUME;
						nxt_byte = 3'h0;
						nxt_crc = crc_sync;
						nxt_sh = {SYNC_BYTE[2:0], 5'h00};
						nxt_state = ST_RXBIT;
					end else begin
						nxt_edges = edges_ff + 2'h1;
					end
				end
			end
			ST_RXBIT: begin
				nxt_gap = gap_ff + 22'h000001;
				if (timed_out) begin
					nxt_state = ST_RECOVER;
					nxt_wait = 24'h000000;
				end else if (!tmr_done) begin
					nxt_tmr = tmr_ff - 16'h0001;
				end else begin
					nxt_tmr = bit_reload;
					if (bidx_ff == BIT_START) begin
						if (rx) begin
							nxt_state = ST_RECOVER;
							nxt_wait = 24'h000000;
						end
						nxt_bidx = bidx_ff + 4'h1;
					end else if (bidx_ff != BIT_STOP) begin
						nxt_sh = {rx, sh_ff[7:1]};
						if (!rx_last) begin
							nxt_crc = swu_crc_step(crc_ff, rx);
						end
						nxt_bidx = bidx_ff + 4'h1;
					end else if (!rx) begin
						nxt_state = ST_RECOVER;
						nxt_wait = 24'h000000;
					end else if (rx_last) begin
						nxt_wait = 24'h000000;
						if (!crc_ok) begin
							nxt_state = ST_RECOVER;
						end else begin
							nxt_bit_good = bit_ff;
							nxt_state = ST_IDLE;
							if (addr_ok && rx_is_write) begin
								nxt_wr_valid = 1'b1;
								nxt_wr = '{reg_addr: rx_reg, data: frame_ff[31:0]};
								nxt_wcnt = wcnt_ff + 8'h01;
							end else if (addr_ok) begin
								nxt_rd_req = 1'b1;
								nxt_rd_addr = rx_reg;
								nxt_state = ST_DELAY;
							end
						end
					end else begin
						nxt_frame = {frame_ff[47:0], sh_ff};
						nxt_byte = byte_ff + 3'h1;
						nxt_state = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				nxt_gap = gap_ff + 22'h000001;
				if (timed_out) begin
					nxt_state = ST_RECOVER;
					nxt_wait = 24'h000000;
				end else if (rx_fall) begin
					// Gap is timed start bit to start bit.
					nxt_gap = 22'h000000;
					nxt_tmr = {1'b0, bit_ff[15:1]};
					nxt_bidx = BIT_START;
					nxt_state = ST_RXBIT;
				end
			end
			ST_RECOVER: begin
				// Any low level restarts the idle count.
				nxt_wait = rx ? wait_ff + 24'h000001 : 24'h000000;
				if (wait_ff >= recover_lim) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_DELAY: begin
				nxt_wait = wait_ff + 24'h000001;
				if (wait_ff >= delay_lim) begin
					nxt_state = ST_TXBIT;
					nxt_frame = {SYNC_BYTE, REPLY_ADDR, 1'b0, rd_addr_ff, rd_data_i};
					nxt_crc = CRC_INIT;
					nxt_byte = 3'h0;
					nxt_bidx = BIT_START;
					nxt_tmr = bit_reload;
				end
			end
			ST_TXBIT: begin
				if (!tmr_done) begin
					nxt_tmr = tmr_ff - 16'h0001;
				end else begin
					nxt_tmr = bit_reload;
					if ((bidx_ff != BIT_START) && (bidx_ff != BIT_STOP) &&
						(byte_ff != WR_LAST_BYTE)) begin
						nxt_crc = swu_crc_step(crc_ff, tx_bit);
					end
					if (bidx_ff != BIT_STOP) begin
						nxt_bidx = bidx_ff + 4'h1;
					end else if (byte_ff == WR_LAST_BYTE) begin
						nxt_state = ST_TAIL;
						nxt_wait = 24'h000000;
					end else begin
						nxt_bidx = BIT_START;
						nxt_byte = byte_ff + 3'h1;
						nxt_frame = {frame_ff[47:0], 8'h00};
					end
				end
			end
			ST_TAIL: begin
				nxt_wait = wait_ff + 24'h000001;
				if (wait_ff >= tail_lim) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// Outside single-wire mode the port stays idle and silent.
		if (!uart_en) begin
			nxt_state = ST_IDLE;
		end
	end

	// Sequencer state; the bit times reset to the slowest legal baud.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 18'h00000;
			edges_ff <= 2'h0;
			bit_ff <= RST_BIT_CYC;
			bit_good_ff <= RST_BIT_CYC;
			tmr_ff <= 16'h0000;
			bidx_ff <= BIT_START;
			byte_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			edges_ff <= nxt_edges;
			bit_ff <= nxt_bit;
			bit_good_ff <= nxt_bit_good;
			tmr_ff <= nxt_tmr;
			bidx_ff <= nxt_bidx;
			byte_ff <= nxt_byte;
		end
	end

	// Datagram data path and counters.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			sh_ff <= 8'h00;
			frame_ff <= 56'h00000000000000;
			crc_ff <= CRC_INIT;
			gap_ff <= 22'h000000;
			wait_ff <= 24'h000000;
			wcnt_ff <= WCNT_RST;
		end else begin
			sh_ff <= nxt_sh;
			frame_ff <= nxt_frame;
			crc_ff <= nxt_crc;
			gap_ff <= nxt_gap;
			wait_ff <= nxt_wait;
			wcnt_ff <= nxt_wcnt;
		end
	end

	// Register bank strobes are one-cycle pulses.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			wr_valid_ff <= 1'b0;
			wr_ff <= '0;
			rd_req_ff <= 1'b0;
			rd_addr_ff <= 7'h00;
		end else begin
			wr_valid_ff <= nxt_wr_valid;
			wr_ff <= nxt_wr;
			rd_req_ff <= nxt_rd_req;
			rd_addr_ff <= nxt_rd_addr;
		end
	end

	// Line drivers are registered, so the line lags the sequencer by a cycle.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			line_out_ff <= 1'b1;
			line_oe_ff <= 1'b0;
		end else begin
			line_out_ff <= (state_ff == ST_TXBIT) ? tx_bit : 1'b1;
			line_oe_ff <= (state_ff == ST_TXBIT) || (state_ff == ST_TAIL);
		end
	end

	// Chain output changes only when software writes it.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			chain_out_ff <= CHAIN_OUT_RST;
		end else if (chain_addr_out_we_i) begin
			chain_out_ff <= chain_addr_out_d_i;
		end
	end

	// Output wiring; the inverted line always mirrors the true one.
	assign line_true_o = line_out_ff;
	assign line_true_oe_o = line_oe_ff;
	assign line_inverted_o = ~line_out_ff;
	assign line_inverted_oe_o = line_oe_ff;
	assign chain_addr_out_o = chain_out_ff;
	assign wr_valid_o = wr_valid_ff;
	assign wr_o = wr_ff;
	assign rd_req_o = rd_req_ff;
	assign rd_addr_o = rd_addr_ff;
	assign write_counter_o = wcnt_ff;

endmodule : swu_port

//--- verif/swu_host.sv
`timescale 1ns/10ps
// Host UART on the shared line: it talks, then lets go so the pull-up holds it high.
module swu_host (
	// Clock and the resolved line level.
	input wire logic mclk_i,
	input wire logic line_i,
	// Drive towards the shared line.
	output logic drv_o,
	output logic en_o,
	// Bytes heard from the device.
	output logic rx_stb_o,
	output logic [7:0] rx_byte_o
);
	int rx_bc = 64;
	logic [7:0] rb;

	// Quiet and released from time zero.
	initial begin
		drv_o = 1'b1;
		en_o = 1'b0;
		rx_stb_o = 1'b0;
		rx_byte_o = 8'h00;
	end

	// One bit held for bc clocks, always changed on the falling edge.
	task automatic put_bit(input logic b, input int bc);
		drv_o = b;
		repeat (bc) @(negedge mclk_i);
	endtask : put_bit

	// Sends n bytes, byte 0 in the low bits first, then releases the line.
	task automatic send(input logic [63:0] d, input int n, input int bc);
		rx_bc = bc;
		@(negedge mclk_i);
		en_o = 1'b1;
		for (int i = 0; i < n; i++) begin
			put_bit(1'b0, bc);
			for (int j = 0; j < 8; j++) begin
				put_bit(d[8*i+j], bc);
			end
			put_bit(1'b1, bc);
		end
		en_o = 1'b0;
	endtask : send

	// A low pulse too short to be a start bit.
	task automatic glitch(input int len);
		@(negedge mclk_i);
		en_o = 1'b1;
		put_bit(1'b0, len);
		put_bit(1'b1, 1);
		en_o = 1'b0;
	endtask : glitch

	// Listens only while released; a byte with a low stop bit is never reported.
	always begin
		@(negedge line_i);
		if (!en_o) begin
			repeat (rx_bc / 2) @(posedge mclk_i);
			for (int j = 0; j < 8; j++) begin
				repeat (rx_bc) @(posedge mclk_i);
				rb[j] = line_i;
			end
			repeat (rx_bc) @(posedge mclk_i);
			rx_byte_o <= rb;
			rx_stb_o <= line_i;
			@(posedge mclk_i);
			rx_stb_o <= 1'b0;
		end
	end
endmodule : swu_host

//--- verif/swu_port_sva.sv
`timescale 1ns/10ps
// Pin-level checks of the port; everything lives in the one system clock domain.
module swu_port_sva
	import swu_pkg::*;
(
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Line drivers and mode pins.
	input wire logic line_true_o,
	input wire logic line_true_oe_o,
	input wire logic line_inverted_o,
	input wire logic line_inverted_oe_o,
	input wire logic four_wire_select_i,
	input wire logic step_direction_select_i,
	// Chain output and its write strobe.
	input wire logic chain_addr_out_o,
	input wire logic chain_addr_out_we_i,
	input wire logic chain_addr_out_d_i,
	// Register bank side.
	input wire logic wr_valid_o,
	input wire swu_wr_t wr_o,
	input wire logic rd_req_o,
	input wire logic [6:0] rd_addr_o,
	input wire logic [7:0] write_counter_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	// A reply opens with a held start bit; its tail is high before release.
	sequence start_bit_s;
		!line_true_o [*8];
	endsequence
	sequence reply_wait_s;
		!line_true_oe_o [*8];
	endsequence

	lines_mirror_a: assert property (line_inverted_o == ~line_true_o &&
		line_inverted_oe_o == line_true_oe_o) else $error("inverted line differs");
	idle_high_a: assert property (!line_true_oe_o |-> line_true_o)
		else $error("line not idle high");
	reply_start_a: assert property ($rose(line_true_oe_o) |-> start_bit_s)
		else $error("reply start bit too short");
	release_tail_a: assert property ($fell(line_true_oe_o) |->
		$past(line_true_o) && $past(line_true_o, 8)) else $error("release without high tail");
	reply_delay_a: assert property (rd_req_o |=> reply_wait_s)
		else $error("reply sent too early");
	mode_quiet_a: assert property ((four_wire_select_i || step_direction_select_i) [*8]
		|-> !line_true_oe_o) else $error("line driven while disabled");
	count_step_a: assert property (wr_valid_o |->
		write_counter_o == $past(write_counter_o) + 8'h01) else $error("counter step wrong");
	count_hold_a: assert property (!wr_valid_o |-> $stable(write_counter_o))
		else $error("counter moved without write");
	pulse_once_a: assert property ((wr_valid_o || rd_req_o) |=> !wr_valid_o && !rd_req_o)
		else $error("result pulse too long");
	wr_hold_a: assert property (!wr_valid_o |-> $stable(wr_o))
		else $error("write data changed");
	rd_addr_hold_a: assert property (!rd_req_o |-> $stable(rd_addr_o))
		else $error("read address changed");
	chain_write_a: assert property (chain_addr_out_we_i |=>
		chain_addr_out_o == $past(chain_addr_out_d_i)) else $error("chain output not written");
	chain_hold_a: assert property (!chain_addr_out_we_i |=> $stable(chain_addr_out_o))
		else $error("chain output moved");
endmodule : swu_port_sva

bind swu_port swu_port_sva swu_port_sva_i (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .line_true_o(line_true_o),
	.line_true_oe_o(line_true_oe_o), .line_inverted_o(line_inverted_o),
	.line_inverted_oe_o(line_inverted_oe_o), .four_wire_select_i(four_wire_select_i),
	.step_direction_select_i(step_direction_select_i), .chain_addr_out_o(chain_addr_out_o),
	.chain_addr_out_we_i(chain_addr_out_we_i), .chain_addr_out_d_i(chain_addr_out_d_i),
	.wr_valid_o(wr_valid_o), .wr_o(wr_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
	.write_counter_o(write_counter_o)
);

//--- verif/swu_port_tb.sv
`timescale 1ns/10ps
// Drives the port from the host side and checks each result it reports.
module swu_port_tb
	import swu_pkg::*;
;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic line_w, h_drv, h_en, rx_stb, line_true_o, line_true_oe_o, wr_valid_o, rd_req_o;
	logic chain_addr_out_o, rise, fall;
	logic [7:0] rx_byte, write_counter_o;
	logic [7:0] node = 8'h00;
	logic sd_sel = 1'b0;
	logic fw_sel = 1'b0;
	logic chain_in = 1'b0;
	logic chain_we = 1'b0;
	logic chain_d = 1'b1;
	logic [3:0] units = 4'h1;
	logic [31:0] rd_data = 32'h0;
	logic [4:0] cases [7] = '{5'h01, 5'h02, 5'h04, 5'h0d, 5'h08, 5'h10, 5'h01};
	swu_wr_t wr_o;
	logic [6:0] rd_addr_o;
	logic [41:0] exp_q[$];
	int err_total = 0;
	int check_count = 0;
	int bc = 64;
	int dly = 0;
	int since_rd = 0;
	int hi_cnt = 0;
	logic oe_q = 1'b0;

	// System clock; the released line is held high by its pull-up.
	always #12.5 mclk_i = ~mclk_i;
	assign line_w = line_true_oe_o ? line_true_o : (h_en ? h_drv : 1'b1);

	swu_port swu_port_i (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .line_true_i(line_w),
		.line_true_o(line_true_o), .line_true_oe_o(line_true_oe_o), .line_inverted_i(~line_w),
		.line_inverted_o(), .line_inverted_oe_o(), .four_wire_select_i(fw_sel),
		.step_direction_select_i(sd_sel), .chain_addr_in_i(chain_in),
		.chain_addr_out_o(chain_addr_out_o), .chain_addr_out_we_i(chain_we),
		.chain_addr_out_d_i(chain_d), .node_address_setting_i(node),
		.reply_delay_setting_i(units), .wr_valid_o(wr_valid_o), .wr_o(wr_o),
		.rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data),
		.write_counter_o(write_counter_o)
	);
	swu_host swu_host_i (
		.mclk_i(mclk_i), .line_i(line_w), .drv_o(h_drv), .en_o(h_en),
		.rx_stb_o(rx_stb), .rx_byte_o(rx_byte)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// An empty queue compares against unknown, so any extra result is a mismatch.
	task automatic take(input logic [41:0] got);
		if (exp_q.size() == 0) cmp(got, 'x);
		else cmp(got, exp_q.pop_front());
	endtask : take

	function automatic logic [7:0] crc8(input logic [63:0] d, input int nb);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < nb; i++) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	// Builds one datagram, lets the host send it, then keeps the line idle.
	task automatic xfer(input logic [7:0] addr, input logic [7:0] regb, input logic [31:0] data,
		input logic bad, input logic take_it);
		logic [63:0] d;
		int n;
		n = regb[7] ? 8 : 4;
		d = {8'h00, data[7:0], data[15:8], data[23:16], data[31:24], regb, addr, 4'($urandom), 4'h5};
		d[8*(n-1)+:8] = crc8(d, 8 * (n - 1)) ^ {7'h0, bad};
		if (take_it) exp_q.push_back({2'h1, 1'b0, regb[6:0], data});
		swu_host_i.send(d, n, bc);
		repeat (13 * bc) @(negedge mclk_i);
	endtask : xfer

	// Waits, within a bound, for every noted result and for the line release.
	task automatic drain(input int lim);
		int k;
		k = 0;
		while ((exp_q.size() != 0 || line_true_oe_o !== 1'b0) && k < lim) begin
			@(negedge mclk_i);
			k++;
		end
		if (k == lim) begin
			err_total++;
			$display("unexpected hang at %0t: got %h expected %h", $time, exp_q.size(), 0);
			tally_and_finish();
		end
	endtask : drain

	// Second process: takes the oldest note for each result and times the reply.
	always @(posedge mclk_i) begin
		since_rd = (rd_req_o === 1'b1) ? 0 : since_rd + 1;
		rise = line_true_oe_o === 1'b1 && oe_q === 1'b0;
		fall = line_true_oe_o === 1'b0 && oe_q === 1'b1;
		if (wr_valid_o === 1'b1) take({2'h1, 1'b0, wr_o});
		if (rd_req_o === 1'b1) take({2'h2, 33'h0, rd_addr_o});
		if (rx_stb === 1'b1) take({2'h3, 32'h0, rx_byte});
		if (rise) cmp(42'(since_rd >= dly && since_rd <= dly + 4), 42'h1);
		if (fall) cmp(42'(hi_cnt >= 84 * bc && hi_cnt <= 84 * bc + 3), 42'h1);
		hi_cnt = (line_true_oe_o === 1'b1) ? hi_cnt + 1 : 0;
		oe_q = line_true_oe_o;
	end

	// Main sequence.
	initial begin
		logic [6:0] r;
		logic [63:0] rep;
		void'($urandom(49383));
		node = 8'($urandom_range(0, 253));
		repeat (10) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		cmp({34'h0, write_counter_o}, 42'h0);
		cmp({41'h0, chain_addr_out_o}, 42'h1);
		// Each case holds glitch, chain, address offset, bad CRC and acceptance bits.
		foreach (cases[i]) begin
			chain_in = cases[i][3];
			if (cases[i][4]) swu_host_i.glitch(8);
			xfer(node + 8'(cases[i][2]), {1'b1, 7'($urandom)}, $urandom, cases[i][1], cases[i][0]);
			drain(2000);
			$display("write case %0d done", i);
		end
		cmp({34'h0, write_counter_o}, 42'h3);
		// A datagram cut after two bytes must time out before the next one is taken.
		swu_host_i.send({48'h0, node, 8'h05}, 2, bc);
		repeat (77 * bc) @(negedge mclk_i);
		xfer(node, {1'b1, 7'($urandom)}, $urandom, 1'b0, 1'b1);
		drain(2000);
		cmp({34'h0, write_counter_o}, 42'h4);
		$display("cut frame test done");
		chain_we = 1'b1;
		chain_d = 1'b0;
		@(negedge mclk_i);
		chain_we = 1'b0;
		cmp({41'h0, chain_addr_out_o}, 42'h0);
		// Four-wire mode must drop a write, step-direction mode a read.
		for (int m = 0; m < 2; m++) begin
			fw_sel = (m == 0);
			sd_sel = (m == 1);
			r = 7'($urandom);
			xfer(node, {(m == 0), r}, $urandom, 1'b0, 1'b0);
			fw_sel = 1'b0;
			sd_sel = 1'b0;
			cmp({41'h0, line_true_oe_o}, 42'h0);
		end
		$display("chain and mode test done");
		// Reads at a faster rate; a zero delay setting behaves as one unit.
		bc = 40;
		chain_in = 1'b0;
		for (int k = 0; k < 2; k++) begin
			units = k ? 4'h0 : 4'h2;
			dly = 8 * (k ? 1 : 2) * bc;
			rd_data = $urandom;
			r = 7'($urandom);
			rep = {8'h00, rd_data[7:0], rd_data[15:8], rd_data[23:16], rd_data[31:24], 1'b0, r,
				8'hff, 8'h05};
			rep[63:56] = crc8(rep, 56);
			exp_q.push_back({2'h2, 33'h0, r});
			for (int i = 0; i < 8; i++) begin
				exp_q.push_back({2'h3, 32'h0, rep[8*i+:8]});
			end
			xfer(node, {1'b0, r}, 32'h0, 1'b0, 1'b0);
			drain(12000);
			$display("read %0d done", k);
		end
		cmp({34'h0, write_counter_o}, 42'h4);
		tally_and_finish();
	end
endmodule : swu_port_tb
